// File: shared/lmr_pkg.sv
// Constants for the mode register bank: addresses, fields, reset values, codes.
// Assumes a single 40 MHz clock domain and a synchronous active-low reset.
package lmr_pkg;
   // ====================================================
   // Mode addresses
   localparam logic [7:0] MA_LATENCY = 8'h02;
   localparam logic [7:0] MA_DRIVE = 8'h03;
   localparam logic [7:0] MA_TEMP = 8'h04;
   localparam logic [7:0] MA_VENDOR = 8'h05;
   localparam logic [7:0] MA_REV1 = 8'h06;
   localparam logic [7:0] MA_REV2 = 8'h07;
   localparam logic [7:0] MA_CONFIG = 8'h08;
   localparam logic [7:0] MA_TEST = 8'h09;
   localparam logic [7:0] MA_CAL = 8'h0A;
   localparam logic [7:0] MA_BANKMASK = 8'h10;
   localparam logic [7:0] MA_DEVINFO = 8'h00;
   // ====================================================
   // Field positions and reset values
   localparam int FLAG_BIT = 7;
   localparam int RATE_MSB = 2;
   localparam int CFG_TYPE_LSB = 0;
   localparam int CFG_DENS_LSB = 2;
   localparam int CFG_WIDTH_LSB = 6;
   localparam int DEVINFO_RZQ_BIT = 5;
   localparam logic [3:0] LAT_RESET = 4'h1;
   localparam logic [3:0] DRV_RESET = 4'h2;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [2:0] RATE_RESET = 3'h3;
   // ====================================================
   // Calibration codes
   localparam logic [7:0] CAL_INIT = 8'hFF;
   localparam logic [7:0] CAL_LONG = 8'hAB;
   localparam logic [7:0] CAL_SHORT = 8'h56;
   localparam logic [7:0] CAL_RESET = 8'hC3;
   // ====================================================
   // Calibration busy counts, in clock cycles
   localparam int CAL_INIT_CYC = 40;
   localparam int CAL_LONG_CYC = 16;
   localparam int CAL_SHORT_CYC = 4;
   localparam logic [7:0] CAL_DEFAULT_CODE = 8'h80;
   typedef enum logic [3:0] {
      LMR_CAL_IDLE = 4'b0001,
      LMR_CAL_RUN = 4'b0010,
      LMR_CAL_DONE = 4'b0100,
      LMR_CAL_DFLT = 4'b1000
   } lmr_cal_state_t;
endpackage

// File: shared/lmr_temp_if.sv
// Carries the refresh-rate status between the sensor tracker and the bank.
// Assumes both ends on the same clock.
`timescale 1ns/100ps
interface lmr_temp_if;
   logic [2:0] rate;
   logic flag;
   logic read_clear;
   modport tracker (output rate, output flag, input read_clear);
   modport bank (input rate, input flag, output read_clear);
endinterface

// File: test/lmr_ctrl_model.sv
// Controller model that issues mode register reads and writes.
// Assumes a single clock; commands change at the falling edge only.
`timescale 1ns/100ps
module lmr_ctrl_model (
   // Clock
   input wire logic clk,
   // Mode register command port
   output logic mr_write,
   output logic mr_read,
   output logic [7:0] mode_address,
   output logic [7:0] operand_bits
);
   // ====================================================
   // Command issue
   initial begin
      mr_write = 1'b0;
      mr_read = 1'b0;
      mode_address = 8'h00;
      operand_bits = 8'h00;
   end
   // Idle bus shows the inverse, so a stale value never looks valid
   // Reserved calibration bytes go out only when the bench asks for them
   task automatic issue(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      mr_write = wr;
      mr_read = ~wr;
      mode_address = a;
      operand_bits = d;
      @(negedge clk);
      mr_write = 1'b0;
      mr_read = 1'b0;
      mode_address = ~a;
      operand_bits = ~d;
   endtask
   // Derating and limit codes are acted on by core timing, not this port
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      issue(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      issue(1'b0, a, 8'h00);
   endtask
endmodule

// File: test/tb.sv
// Self-checking bench for the mode register bank.
// Assumes the controller model drives all command inputs.
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
   import lmr_pkg::*;
   localparam logic [7:0] VEND = 8'h3C; // Arbitrary value
   localparam logic [7:0] REV1 = 8'h11; // Arbitrary value
   localparam logic [7:0] REV2 = 8'h22; // Arbitrary value
   localparam logic [3:0] DENS = 4'h9; // Arbitrary value
   logic clk, reset_n, mr_write, mr_read, read_valid, ref_at_supply;
   logic derate_timing, over_85c, cal_busy;
   logic [7:0] mode_address, operand_bits, read_data, bank_refresh_mask, cal_code, e, m;
   logic [3:0] read_latency, write_latency, drive_strength, exp_rl, exp_wl, exp_ds;
   logic [2:0] sensor_rate;
   logic [7:0] exp_q[$];
   int n_mismatch, n_tests, k;
   // ====================================================
   // Design and controller
   lmr_mode_bank #(.VENDOR_ID(VEND), .REVISION_ONE(REV1), .REVISION_TWO(REV2),
      .MEM_TYPE(2'h0), .DENSITY(DENS), .IO_WIDTH(2'h1)) i_lmr_mode_bank (
      .clk(clk), .reset_n(reset_n), .mr_write(mr_write), .mr_read(mr_read),
      .mode_address(mode_address), .operand_bits(operand_bits), .read_data(read_data),
      .read_valid(read_valid), .sensor_rate(sensor_rate), .ref_at_supply(ref_at_supply),
      .read_latency(read_latency), .write_latency(write_latency),
      .drive_strength(drive_strength), .bank_refresh_mask(bank_refresh_mask),
      .derate_timing(derate_timing), .over_85c(over_85c), .cal_busy(cal_busy),
      .cal_code(cal_code));
   lmr_ctrl_model i_lmr_ctrl_model (.clk(clk), .mr_write(mr_write), .mr_read(mr_read),
      .mode_address(mode_address), .operand_bits(operand_bits));
   // ====================================================
   // Clock, monitor, watchdog
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(negedge clk) begin
      if (read_valid === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
         `CHK(read_data, e)
      end
   end
   initial begin
      #(25 * 20000);
      n_mismatch++;
      finish_test();
   end
   // ====================================================
   // Tasks
   task automatic finish_test();
      if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic do_reset();
      @(negedge clk);
      reset_n = 1'b0;
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      i_lmr_ctrl_model.rd(a);
      repeat (2) @(negedge clk);
   endtask
   task automatic wr_wait(input logic [7:0] a, input logic [7:0] d);
      i_lmr_ctrl_model.wr(a, d);
      repeat (3) @(negedge clk);
   endtask
   // Busy must match busy_exp the cycle after the write, then fall within a bound
   task automatic cal_run(input logic [7:0] code, input logic busy_exp);
      i_lmr_ctrl_model.wr(MA_CAL, code);
      `CHK(cal_busy, busy_exp)
      for (k = 0; k < 100 && cal_busy !== 1'b0; k++) @(negedge clk);
      `CHK(cal_busy, 1'b0)
   endtask
   // ====================================================
   // Main sequence
   initial begin
      reset_n = 1'b0;
      sensor_rate = 3'h3;
      ref_at_supply = 1'b1;
      n_mismatch = 0;
      n_tests = 0;
      void'($urandom(32'h29BE));
      do_reset();
      `CHK(read_latency, 4'h3)
      `CHK(write_latency, 4'h1)
      `CHK(drive_strength, DRV_RESET)
      `CHK(bank_refresh_mask, 8'h00)
      rd_exp(MA_TEMP, 8'h03);
      cal_run(CAL_INIT, 1'b0);
      rd_exp(MA_DEVINFO, 8'h00);
      ref_at_supply = 1'b0;
      do_reset();
      // Every latency and drive code, reserved ones must leave the setting alone
      exp_rl = 4'h3;
      exp_wl = 4'h1;
      exp_ds = DRV_RESET;
      for (int c = 15; c >= 0; c--) begin
         case (c)
            1: begin exp_rl = 4'h3; exp_wl = 4'h1; end
            2: begin exp_rl = 4'h4; exp_wl = 4'h2; end
            3: begin exp_rl = 4'h5; exp_wl = 4'h2; end
            4: begin exp_rl = 4'h6; exp_wl = 4'h3; end
            5: begin exp_rl = 4'h7; exp_wl = 4'h4; end
            6: begin exp_rl = 4'h8; exp_wl = 4'h4; end
            default: ;
         endcase
         if (c inside {1, 2, 3, 4, 6, 7}) exp_ds = c[3:0];
         wr_wait(MA_LATENCY, {4'hF, c[3:0]});
         `CHK({read_latency, write_latency}, {exp_rl, exp_wl})
         wr_wait(MA_DRIVE, {4'h0, c[3:0]});
         `CHK(drive_strength, exp_ds)
      end
      for (int i = 0; i < 5; i++) begin
         m = (i == 0) ? 8'hFF : 8'($urandom());
         wr_wait(MA_BANKMASK, m);
         `CHK(bank_refresh_mask, m)
      end
      rd_exp(MA_VENDOR, VEND);
      rd_exp(MA_REV1, REV1);
      rd_exp(MA_REV2, REV2);
      rd_exp(MA_CONFIG, {2'h1, DENS, 2'h0});
      rd_exp(8'h20 | 8'($urandom() & 32'h1F), 8'h00);
      // Each step changes the code, so the flag must be up, then cleared by the read
      for (int r = 0; r < 8; r++) begin
         sensor_rate = r[2:0];
         repeat (6) @(negedge clk);
         `CHK(over_85c, r[2])
         `CHK(derate_timing, (r == 6))
         rd_exp(MA_TEMP, {1'b1, 4'h0, r[2:0]});
         rd_exp(MA_TEMP, {1'b0, 4'h0, r[2:0]});
      end
      cal_run(8'h12, 1'b0);
      cal_run(CAL_INIT, 1'b1);
      rd_exp(MA_DEVINFO, 8'(1 << DEVINFO_RZQ_BIT));
      cal_run(CAL_LONG, 1'b1);
      cal_run(CAL_SHORT, 1'b1);
      i_lmr_ctrl_model.wr(MA_CAL, CAL_RESET);
      for (k = 0; k < 100 && cal_busy !== 1'b0; k++) @(negedge clk);
      repeat (3) @(negedge clk);
      `CHK(cal_code, CAL_DEFAULT_CODE)
      repeat (5) @(negedge clk);
      `CHK(exp_q.size(), 0)
      finish_test();
   end
endmodule

// File: verilog/lmr_mode_bank.sv
// Mode register bank: latency, drive, temperature status, identity,
// calibration and bank refresh mask, reached by mode register read/write.
// Assumes commands already decoded on clk; sensor and strap pins are async.
//
// What this block does
// - Latency code 1..6 selects read/write latency pair; reset gives 3/1.
// - Drive code selects impedance; default 40 ohm; 0, 5, above 7 reserved.
// - Refresh-rate field reports sensor code 0..7 with its meaning.
// - Codes 5 and 6 mean quarter refresh; 6 asks for derating.
// - Change flag sets when refresh-rate bits change since last read.
// - Reading temperature status clears the change flag.
// - Change flag is zero after power-up.
// - Refresh-rate top bit high means above 85 C.
// - Address 5 returns an eight-bit vendor code.
// - Addresses 6 and 7 return eight-bit revision codes.
// - Address 8 reports type, density and interface width.
// - Calibration writes FF, AB, 56 start init, long, short calibration.
// - Reserved calibration writes are ignored.
// - Reference pin at supply: default only, calibration commands ignored.
// - Init calibration updates device information with resistor presence.
// - Bank mask bit n blocks refresh of bank n; default zero.
`timescale 1ns/100ps
module lmr_mode_bank
   import lmr_pkg::*;
#(
   parameter logic [7:0] VENDOR_ID = 8'h5A, // Arbitrary value
   parameter logic [7:0] REVISION_ONE = 8'hA1, // Arbitrary value
   parameter logic [7:0] REVISION_TWO = 8'hB2, // Arbitrary value
   parameter logic [1:0] MEM_TYPE = 2'h0,
   parameter logic [3:0] DENSITY = 4'h7, // Arbitrary value
   parameter logic [1:0] IO_WIDTH = 2'h0
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Mode register command port
   input wire logic mr_write,
   input wire logic mr_read,
   input wire logic [7:0] mode_address,
   input wire logic [7:0] operand_bits,
   output logic [7:0] read_data,
   output logic read_valid,
   // Pins from outside
   input wire logic [2:0] sensor_rate,
   input wire logic ref_at_supply,
   // Settings
   output logic [3:0] read_latency,
   output logic [3:0] write_latency,
   output logic [3:0] drive_strength,
   output logic [7:0] bank_refresh_mask,
   output logic derate_timing,
   output logic over_85c,
   // Calibration
   output logic cal_busy,
   output logic [7:0] cal_code
);
   // ====================================================
   // Input synchronisers
   logic [2:0] rate_s1_q, rate_s2_q;
   logic [2:0] rate_s3_q;
   logic strap_s1_q, strap_s2_q;
   always_ff @(posedge clk) begin
      rate_s1_q <= sensor_rate;
      rate_s2_q <= rate_s1_q;
      rate_s3_q <= rate_s2_q;
      strap_s1_q <= ref_at_supply;
      strap_s2_q <= strap_s1_q;
   end

   // ====================================================
   // Decoding
   function automatic logic [7:0] lat_pair(input logic [3:0] code);
      case (code)
         4'h1: lat_pair = {4'h3, 4'h1};
         4'h2: lat_pair = {4'h4, 4'h2};
         4'h3: lat_pair = {4'h5, 4'h2};
         4'h4: lat_pair = {4'h6, 4'h3};
         4'h5: lat_pair = {4'h7, 4'h4};
         4'h6: lat_pair = {4'h8, 4'h4};
         default: lat_pair = 8'h00;
      endcase
   endfunction

   function automatic logic drv_legal(input logic [3:0] code);
      drv_legal = (code >= 4'h1) && (code <= 4'h7) && (code != 4'h5);
   endfunction

   localparam logic [7:0] LAT_RESET_PAIR = lat_pair(LAT_RESET);

   wire wr_lat = mr_write && (mode_address == MA_LATENCY);
   wire wr_drv = mr_write && (mode_address == MA_DRIVE);
   wire wr_cal = mr_write && (mode_address == MA_CAL);
   wire wr_mask = mr_write && (mode_address == MA_BANKMASK);
   wire rd_temp = mr_read && (mode_address == MA_TEMP);
   wire lat_ok = (lat_pair(operand_bits[3:0]) != 8'h00);
   wire drv_ok = drv_legal(operand_bits[3:0]);
   wire cal_legal = (operand_bits == CAL_INIT) || (operand_bits == CAL_LONG) ||
      (operand_bits == CAL_SHORT) || (operand_bits == CAL_RESET);
   // Strap at supply ignores every calibration command
   wire cal_accept = wr_cal && cal_legal && !strap_s2_q && !cal_busy;

   // ====================================================
   // Temperature tracker
   lmr_temp_if tif ();
   // Code bits may settle a cycle apart; only a code seen twice in a row goes on
   wire [2:0] rate_steady = (rate_s2_q == rate_s3_q) ? rate_s2_q : tif.rate;
   lmr_temp_track u_track (
      .clk(clk),
      .reset_n(reset_n),
      .sensor_rate(rate_steady),
      .tif(tif)
   );
   assign tif.read_clear = rd_temp;

   // ====================================================
   // Writable registers
   logic [3:0] lat_q, drv_q;
   logic [7:0] mask_q;
   logic rzq_seen_q;
   logic [7:0] lat_now;
   assign lat_now = lat_pair(lat_q);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lat_q <= LAT_RESET;
         drv_q <= DRV_RESET;
         mask_q <= MASK_RESET;
      end else begin
         if (wr_lat && lat_ok) begin
            lat_q <= operand_bits[3:0];
         end
         if (wr_drv && drv_ok) begin
            drv_q <= operand_bits[3:0];
         end
         if (wr_mask) begin
            mask_q <= operand_bits;
         end
      end
   end

   // ====================================================
   // Calibration sequencer
   lmr_cal_state_t cal_q, cal_d;
   logic [7:0] cnt_q, cnt_d;
   logic [7:0] cal_len;
   logic [7:0] ccode_q;
   logic cal_is_init_q;
   assign cal_len = (operand_bits == CAL_INIT) ? 8'(CAL_INIT_CYC) :
      (operand_bits == CAL_LONG) ? 8'(CAL_LONG_CYC) : 8'(CAL_SHORT_CYC);

   always_comb begin
      cal_d = cal_q;
      cnt_d = cnt_q;
      case (cal_q)
         LMR_CAL_IDLE: begin
            if (cal_accept && operand_bits == CAL_RESET) begin
               cal_d = LMR_CAL_DFLT;
            end else if (cal_accept) begin
               cal_d = LMR_CAL_RUN;
               cnt_d = cal_len;
            end
         end
         LMR_CAL_RUN: begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
               cal_d = LMR_CAL_DONE;
            end
         end
         LMR_CAL_DONE: cal_d = LMR_CAL_IDLE;
         LMR_CAL_DFLT: cal_d = LMR_CAL_IDLE;
         default: cal_d = LMR_CAL_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cal_q <= LMR_CAL_IDLE;
         cnt_q <= 8'h00;
         ccode_q <= CAL_DEFAULT_CODE;
         cal_is_init_q <= 1'b0;
         rzq_seen_q <= 1'b0;
      end else begin
         cal_q <= cal_d;
         cnt_q <= cnt_d;
         if (cal_accept) begin
            cal_is_init_q <= (operand_bits == CAL_INIT);
         end
         // Real impedance search is analogue; the code here just nudges
         if (cal_q == LMR_CAL_DONE) begin
            ccode_q <= ccode_q ^ 8'h01;
            if (cal_is_init_q) begin
               rzq_seen_q <= 1'b1;
            end
         end
         if (cal_q == LMR_CAL_DFLT) begin
            ccode_q <= CAL_DEFAULT_CODE;
         end
      end
   end

   // ====================================================
   // Read path
   wire [7:0] temp_word = {tif.flag, 4'h0, tif.rate};
   wire [7:0] cfg_word = {IO_WIDTH, DENSITY, MEM_TYPE};
   logic [7:0] rd_mux;
   always_comb begin
      case (mode_address)
         MA_DEVINFO: rd_mux = 8'(rzq_seen_q) << DEVINFO_RZQ_BIT;
         MA_TEMP: rd_mux = temp_word;
         MA_VENDOR: rd_mux = VENDOR_ID;
         MA_REV1: rd_mux = REVISION_ONE;
         MA_REV2: rd_mux = REVISION_TWO;
         MA_CONFIG: rd_mux = cfg_word;
         // Test mode and write-only registers read as zero
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         read_data <= 8'h00;
         read_valid <= 1'b0;
         read_latency <= LAT_RESET_PAIR[7:4];
         write_latency <= LAT_RESET_PAIR[3:0];
         drive_strength <= DRV_RESET;
         bank_refresh_mask <= MASK_RESET;
         derate_timing <= 1'b0;
         over_85c <= 1'b0;
         cal_busy <= 1'b0;
         cal_code <= CAL_DEFAULT_CODE;
      end else begin
         read_data <= mr_read ? rd_mux : 8'h00;
         read_valid <= mr_read;
         read_latency <= lat_now[7:4];
         write_latency <= lat_now[3:0];
         drive_strength <= drv_q;
         bank_refresh_mask <= mask_q;
         derate_timing <= (tif.rate == 3'h6);
         over_85c <= tif.rate[RATE_MSB];
         cal_busy <= (cal_d != LMR_CAL_IDLE);
         cal_code <= ccode_q;
      end
   end

   // ====================================================
   // Checks
   a_lat_reserved_keep: assert property (@(posedge clk) disable iff (!reset_n)
      wr_lat && !lat_ok |=> $stable(lat_q))
      else $error("latency changed");
   a_lat_pair_out: assert property (@(posedge clk) disable iff (!reset_n)
      wr_lat && operand_bits[3:0] == 4'h4 ##2 1 |-> read_latency == 4'h6 && write_latency == 4'h3)
      else $error("latency pair wrong");
   // Reset values are looked at while reset is low, so no disable here
   a_lat_reset_pair: assert property (@(posedge clk)
      !reset_n |=> read_latency == 4'h3 && write_latency == 4'h1)
      else $error("latency reset pair");
   a_lat_legal_range: assert property (@(posedge clk) disable iff (!reset_n)
      read_latency >= 4'h3 && read_latency <= 4'h8 && write_latency >= 4'h1)
      else $error("latency out of range");
   a_drv_reserved: assert property (@(posedge clk) disable iff (!reset_n)
      wr_drv && operand_bits[3:0] == 4'h5 |=> $stable(drv_q))
      else $error("drive took 5");
   a_drv_code_out: assert property (@(posedge clk) disable iff (!reset_n)
      wr_drv && drv_ok |-> ##2 drive_strength == $past(operand_bits[3:0], 2))
      else $error("drive code not applied");
   a_drv_reserved_keep: assert property (@(posedge clk) disable iff (!reset_n)
      wr_drv && !drv_ok |=> $stable(drv_q))
      else $error("drive changed");
   a_settings_reset: assert property (@(posedge clk)
      !reset_n |=> drive_strength == DRV_RESET && bank_refresh_mask == MASK_RESET)
      else $error("settings reset");
   a_mask_out: assert property (@(posedge clk) disable iff (!reset_n)
      wr_mask |-> ##2 bank_refresh_mask == $past(operand_bits, 2))
      else $error("mask");
   a_mask_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !wr_mask |=> $stable(mask_q))
      else $error("mask changed without write");

   // ====================================================
   // Calibration checks
   a_cal_ignored: assert property (@(posedge clk) disable iff (!reset_n)
      wr_cal && (!cal_legal || strap_s2_q) && cal_q == LMR_CAL_IDLE |=> cal_q == LMR_CAL_IDLE)
      else $error("bad calibration started");
   a_cal_strap_idle: assert property (@(posedge clk) disable iff (!reset_n)
      wr_cal && strap_s2_q && !cal_busy |=> !cal_busy)
      else $error("calibration ran with strap at supply");
   a_cal_busy_start: assert property (@(posedge clk) disable iff (!reset_n)
      cal_accept |=> cal_busy)
      else $error("busy missing");
   a_cal_short_len: assert property (@(posedge clk) disable iff (!reset_n)
      cal_accept && operand_bits == CAL_SHORT |=> (cal_q == LMR_CAL_RUN) [*4] ##1
      cal_q == LMR_CAL_DONE)
      else $error("short calibration length");
   a_cal_long_len: assert property (@(posedge clk) disable iff (!reset_n)
      cal_accept && operand_bits == CAL_LONG |-> ##16 cal_q == LMR_CAL_RUN ##1
      cal_q == LMR_CAL_DONE)
      else $error("long calibration length");
   a_cal_init_len: assert property (@(posedge clk) disable iff (!reset_n)
      cal_accept && operand_bits == CAL_INIT |-> ##40 cal_q == LMR_CAL_RUN ##1
      cal_q == LMR_CAL_DONE)
      else $error("init calibration length");
   a_cal_dflt_code: assert property (@(posedge clk) disable iff (!reset_n)
      cal_accept && operand_bits == CAL_RESET |-> ##3 cal_code == CAL_DEFAULT_CODE)
      else $error("default code missing");
   a_rzq_after_init: assert property (@(posedge clk) disable iff (!reset_n)
      cal_q == LMR_CAL_DONE && cal_is_init_q |=> rzq_seen_q)
      else $error("resistor presence not noted");
   a_devinfo_read: assert property (@(posedge clk) disable iff (!reset_n)
      mr_read && mode_address == MA_DEVINFO |=> read_data[DEVINFO_RZQ_BIT] == $past(rzq_seen_q))
      else $error("device information read");

   // ====================================================
   // Read path checks
   a_temp_read_word: assert property (@(posedge clk) disable iff (!reset_n)
      rd_temp |=> read_valid && read_data[2:0] == $past(tif.rate))
      else $error("temperature read");
   a_temp_read_flag: assert property (@(posedge clk) disable iff (!reset_n)
      rd_temp |=> read_data[FLAG_BIT] == $past(tif.flag) && read_data[6:3] == 4'h0)
      else $error("temperature flag read");
   a_derate_code: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 derate_timing == ($past(tif.rate) == 3'h6))
      else $error("derate flag");
   a_hot_flag: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 over_85c == $past(tif.rate[2]))
      else $error("85C flag");
   a_vendor_read: assert property (@(posedge clk) disable iff (!reset_n)
      mr_read && mode_address == MA_VENDOR |=> read_data == VENDOR_ID)
      else $error("vendor read");
   a_rev_read: assert property (@(posedge clk) disable iff (!reset_n)
      mr_read && mode_address == MA_REV2 |=> read_data == REVISION_TWO)
      else $error("revision read");
   a_cfg_read: assert property (@(posedge clk) disable iff (!reset_n)
      mr_read && mode_address == MA_CONFIG |=> read_data[CFG_WIDTH_LSB +: 2] == IO_WIDTH &&
      read_data[CFG_DENS_LSB +: 4] == DENSITY && read_data[CFG_TYPE_LSB +: 2] == MEM_TYPE)
      else $error("configuration read");
endmodule

// File: verilog/lmr_temp_track.sv
// Tracks the sensor refresh-rate code and keeps the sticky change flag.
// Assumes the sensor code is already synchronised to clk.
`timescale 1ns/100ps
module lmr_temp_track
   import lmr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Sensor
   input wire logic [2:0] sensor_rate,
   // Bank side
   lmr_temp_if.tracker tif
);
   logic [2:0] rate_q;
   logic flag_q;
   wire changed = (sensor_rate != rate_q);
   wire flag_d = changed | (flag_q & ~tif.read_clear);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rate_q <= RATE_RESET;
         flag_q <= 1'b0;
      end else begin
         rate_q <= sensor_rate;
         flag_q <= flag_d;
      end
   end
   assign tif.rate = rate_q;
   assign tif.flag = flag_q;

   // Set wins over the read clear
   a_flag_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
      changed |=> flag_q) else $error("change flag not set");
   a_flag_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
      tif.read_clear && !changed |=> !flag_q) else $error("flag not cleared");
endmodule
